//--- swd_pkg.sv
// Package of register offsets, field positions and timing counts for the watchdog
package swd_pkg;

  // ----------------------------------------
  // Register indices
  // ----------------------------------------
  localparam logic [7:0] ADDR_CTRL_MODE = 8'hf5;
  localparam logic [7:0] ADDR_COUNTER = 8'hf6;
  localparam logic [7:0] ADDR_CTRL_STAT = 8'hf7;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [7:0] RST_CTRL_MODE = 8'h00;
  localparam logic [7:0] RST_COUNTER = 8'h00;
  localparam logic [7:0] RST_CTRL_STAT = 8'h00;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int BIT_KEYBOARD_RESET_OUTPUT_EN = 1;
  localparam int BIT_KBC_TRIG = 2;
  localparam int BIT_MINUTE = 3;
  localparam int BIT_FAST = 4;
  localparam int BIT_KBD_RELOAD = 6;
  localparam int BIT_MOUSE_RELOAD = 7;
  localparam logic [7:0] MODE_WR_MASK = 8'hde;
  localparam logic [7:0] STAT_WR_MASK = 8'hcf;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_HZ = 10_000_000;
  localparam int MS_PER_SEC = 1000;
  localparam int SEC_PER_MIN = 60;
  localparam int FAST_RATIO = 1000;
  localparam int MS_CYCLES = CLK_HZ / MS_PER_SEC;
  localparam int KEYBOARD_RESET_OUTPUT_PULSE_US = 10;
  localparam int KEYBOARD_RESET_OUTPUT_PULSE_CYCLES = (KEYBOARD_RESET_OUTPUT_PULSE_US * (CLK_HZ / 1_000_000) < 1) ? 1 :
    KEYBOARD_RESET_OUTPUT_PULSE_US * (CLK_HZ / 1_000_000);

  // ----------------------------------------
  // Carrier types
  // ----------------------------------------
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } swd_req_t;

  typedef struct packed {
    logic mouse_irq;
    logic kbd_irq;
    logic kbc_reset;
  } swd_evt_t;

endpackage

//--- swd_tick_gen.sv
// Prescaler producing one-cycle unit ticks for the watchdog countdown
`timescale 1ns/1ps
module swd_tick_gen #(
  parameter int MS_CYC = swd_pkg::MS_CYCLES
) (
  // Clock, reset and enable
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  // Rate selection
  input wire logic minute,
  input wire logic fast,
  // Tick out
  output logic tick
);
  localparam int MAXSUB = swd_pkg::MS_PER_SEC * swd_pkg::SEC_PER_MIN;

  // Zero cycles per millisecond would leave the prescaler with no period
  if (MS_CYC < 1) begin
    $error("swd_tick_gen: MS_CYC must be at least 1");
  end

  logic [31:0] ms_cnt_ff;
  logic [31:0] sub_cnt_ff;
  logic tick_ff;
  wire ms_tick = (ms_cnt_ff == 32'(MS_CYC - 1));
  // Fast mode: one tick per ms (seconds) or per 60 ms (minutes) [RULE3]
  wire [31:0] sub_limit = fast ? (minute ? 32'(swd_pkg::SEC_PER_MIN) : 32'd1) :
                          (minute ? 32'(MAXSUB) : 32'(swd_pkg::MS_PER_SEC)); // [RULE2]
  // Compare with >= so a unit change lands at the next tick [RULE14]
  wire sub_done = ms_tick && (sub_cnt_ff + 32'd1 >= sub_limit);

  always_ff @(posedge mclk) begin
    if (rst) begin
      ms_cnt_ff <= '0;
      sub_cnt_ff <= '0;
      tick_ff <= 1'b0;
    end else if (ce) begin
      ms_cnt_ff <= ms_tick ? '0 : ms_cnt_ff + 32'd1; // [RULE14]
      sub_cnt_ff <= sub_done ? '0 : (ms_tick ? sub_cnt_ff + 32'd1 : sub_cnt_ff);
      tick_ff <= sub_done;
    end
  end

  assign tick = tick_ff;
endmodule

//--- swd_watchdog.sv
// Watchdog timer top with indexed configuration registers
//
// Function
// RULE1 - Expiry resets processor or raises interrupt
// RULE2 - Bit 3 selects second or minute unit
// RULE3 - Bit 4 counts thousand times faster
// RULE4 - Bit 2: controller reset rise forces timeout
// RULE5 - Bit 1 enables low keyboard reset pulse
// RULE6 - Non-zero counter write loads and starts
// RULE7 - Enabled mouse/keyboard interrupts reload last value
// RULE8 - Counter read returns live count
// RULE9 - Zero disables; one expires after unit
// RULE10 - All ones expires after 255 units
// RULE11 - Status bits 7/6 enable mouse/keyboard reload
// RULE12 - Host unlocks, selects, activates before programming
// RULE13 - Single timeout then stop until reload
// RULE14 - Prescaler ticks; unit change at next tick
`timescale 1ns/1ps
module swd_watchdog #(
  parameter int MS_CYC = swd_pkg::MS_CYCLES,
  parameter int PULSE_CYC = swd_pkg::KEYBOARD_RESET_OUTPUT_PULSE_CYCLES
) (
  // Clock, reset, enable
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  // Configuration data port, already unlocked and selected by the host
  input wire swd_pkg::swd_req_t req,
  output logic [7:0] rdata,
  // Event inputs
  input wire swd_pkg::swd_evt_t evt,
  // Time-out outputs
  output logic timeout_reset,
  output logic timeout_irq,
  output logic keyboard_reset_output_n
);
  // ----------------------------------------
  // Parameter checks
  // ----------------------------------------
  // The pulse timer is 16 bits wide, so longer pulses cannot be served
  if (PULSE_CYC < 1 || PULSE_CYC > 65535) begin
    $error("swd_watchdog: PULSE_CYC out of range");
  end
  if (MS_CYC < 1) begin
    $error("swd_watchdog: MS_CYC must be at least 1");
  end

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // Exact index match; a partial decode would alias other devices
  function automatic logic idx_hit(input logic [7:0] addr, input logic [7:0] idx);
    return addr == idx;
  endfunction

  // Keeps reserved bits at zero whatever the host writes
  function automatic logic [7:0] masked(input logic [7:0] value, input logic [7:0] mask);
    return value & mask;
  endfunction

  // ----------------------------------------
  // Register file
  // ----------------------------------------
  logic [7:0] mode_ff;
  logic [7:0] nxt_mode;
  logic [7:0] stat_ff;
  logic [7:0] nxt_stat;
  logic [7:0] load_ff;
  logic [7:0] nxt_load;
  logic [7:0] count_ff;
  logic [7:0] nxt_count;
  logic kbc_prev_ff;
  logic mouse_prev_ff;
  logic kbd_prev_ff;
  logic reset_ff;
  logic irq_ff;
  logic [15:0] pulse_ff;
  logic [15:0] nxt_pulse;
  logic keyboard_reset_output_n_ff;
  logic nxt_keyboard_reset_output_n;
  logic [7:0] rdata_ff;
  logic [7:0] nxt_rdata;
  logic tick;

  // ----------------------------------------
  // Register decode
  // ----------------------------------------
  // Host software handles unlock and device activation outside this block [RULE12]
  wire hit_mode = idx_hit(req.addr, swd_pkg::ADDR_CTRL_MODE);
  wire hit_count = idx_hit(req.addr, swd_pkg::ADDR_COUNTER);
  wire hit_stat = idx_hit(req.addr, swd_pkg::ADDR_CTRL_STAT);
  wire wr_mode = req.wr && hit_mode;
  wire wr_count = req.wr && hit_count;
  wire wr_stat = req.wr && hit_stat;
  wire wr_nonzero = wr_count && (req.wdata != 8'h00); // [RULE6]

  // ----------------------------------------
  // Event detection
  // ----------------------------------------
  // Only rising edges count, so a level held high acts once
  wire kbc_rise = evt.kbc_reset && !kbc_prev_ff;
  wire mouse_rise = evt.mouse_irq && !mouse_prev_ff;
  wire kbd_rise = evt.kbd_irq && !kbd_prev_ff;
  wire kbc_trig = kbc_rise && mode_ff[swd_pkg::BIT_KBC_TRIG]; // [RULE4]
  wire mouse_rl = mouse_rise && stat_ff[swd_pkg::BIT_MOUSE_RELOAD]; // [RULE11]
  wire kbd_rl = kbd_rise && stat_ff[swd_pkg::BIT_KBD_RELOAD]; // [RULE11]
  // A reload with nothing loaded yet would only restart from zero
  wire reload = (mouse_rl || kbd_rl) && (load_ff != 8'h00); // [RULE7]

  // ----------------------------------------
  // Countdown
  // ----------------------------------------
  wire count_live = (count_ff != 8'h00); // [RULE9]
  wire count_last = (count_ff == 8'h01);
  wire count_step = tick && count_live;
  // Any counter write cancels an expiry due in the same cycle
  // Expiry fires once at the 1 to 0 step; zero stays idle [RULE9] [RULE10] [RULE13]
  wire expire = count_step && count_last && !wr_count && !reload;
  wire timeout = expire || kbc_trig; // [RULE1]

  // Write beats reload beats countdown
  assign nxt_count = wr_count ? req.wdata :
                     reload ? load_ff :
                     count_step ? count_ff - 8'h01 : count_ff;
  assign nxt_load = wr_nonzero ? req.wdata : load_ff; // [RULE7]
  assign nxt_mode = wr_mode ? masked(req.wdata, swd_pkg::MODE_WR_MASK) : mode_ff;
  assign nxt_stat = wr_stat ? masked(req.wdata, swd_pkg::STAT_WR_MASK) : stat_ff; // [RULE11]

  // ----------------------------------------
  // Read-back
  // ----------------------------------------
  // Live count on read, not the loaded value [RULE8]
  assign nxt_rdata = hit_mode ? mode_ff :
                     hit_count ? count_ff :
                     hit_stat ? stat_ff : 8'h00;

  swd_tick_gen #(
    .MS_CYC(MS_CYC)
  ) u_tick (
    .mclk(mclk),
    .rst(rst),
    .ce(ce),
    .minute(mode_ff[swd_pkg::BIT_MINUTE]), // [RULE2]
    .fast(mode_ff[swd_pkg::BIT_FAST]), // [RULE3]
    .tick(tick)
  );

  // ----------------------------------------
  // Keyboard reset pulse
  // ----------------------------------------
  // A time-out during a pulse restarts it, so the low time never shortens
  wire pulse_start = timeout && mode_ff[swd_pkg::BIT_KEYBOARD_RESET_OUTPUT_EN]; // [RULE5]
  wire pulse_run = (pulse_ff > 16'h0001);
  assign nxt_pulse = pulse_start ? 16'(PULSE_CYC) :
                     pulse_run ? pulse_ff - 16'h0001 : 16'h0000;
  assign nxt_keyboard_reset_output_n = !(pulse_start || pulse_run);

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge mclk) begin
    if (rst) begin
      mode_ff <= swd_pkg::RST_CTRL_MODE;
      stat_ff <= swd_pkg::RST_CTRL_STAT;
    end else if (ce) begin
      mode_ff <= nxt_mode; // [RULE2] [RULE3]
      stat_ff <= nxt_stat;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      load_ff <= swd_pkg::RST_COUNTER;
      count_ff <= swd_pkg::RST_COUNTER;
    end else if (ce) begin
      load_ff <= nxt_load;
      count_ff <= nxt_count; // [RULE6]
    end
  end

  // Event history resets low, the idle level of every event pin
  always_ff @(posedge mclk) begin
    if (rst) begin
      kbc_prev_ff <= 1'b0;
      mouse_prev_ff <= 1'b0;
      kbd_prev_ff <= 1'b0;
    end else if (ce) begin
      kbc_prev_ff <= evt.kbc_reset;
      mouse_prev_ff <= evt.mouse_irq;
      kbd_prev_ff <= evt.kbd_irq;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      rdata_ff <= 8'h00;
    end else if (ce) begin
      rdata_ff <= nxt_rdata;
    end
  end

  // ----------------------------------------
  // Time-out outputs
  // ----------------------------------------
  // Reset and interrupt are one-cycle pulses; the board picks which is wired
  always_ff @(posedge mclk) begin
    if (rst) begin
      reset_ff <= 1'b0;
      irq_ff <= 1'b0;
    end else if (ce) begin
      reset_ff <= timeout; // [RULE1]
      irq_ff <= timeout; // [RULE1]
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      pulse_ff <= 16'h0000;
      keyboard_reset_output_n_ff <= 1'b1;
    end else if (ce) begin
      pulse_ff <= nxt_pulse;
      keyboard_reset_output_n_ff <= nxt_keyboard_reset_output_n; // [RULE5]
    end
  end

  assign rdata = rdata_ff;
  assign timeout_reset = reset_ff;
  assign timeout_irq = irq_ff;
  assign keyboard_reset_output_n = keyboard_reset_output_n_ff;
endmodule

//--- swd_sva.sv
// Port checker for the watchdog
`timescale 1ns/1ps
module swd_sva #(parameter int PULSE_CYC = 4) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  input wire swd_pkg::swd_req_t req,
  input wire logic [7:0] rdata,
  input wire swd_pkg::swd_evt_t evt,
  input wire logic timeout_reset,
  input wire logic timeout_irq,
  input wire logic keyboard_reset_output_n
);
  logic [7:0] mode_ff;
  wire kb_n = keyboard_reset_output_n;
  always_ff @(posedge mclk) begin
    if (rst) mode_ff <= 8'h00;
    else if (ce && req.wr && req.addr == swd_pkg::ADDR_CTRL_MODE) mode_ff <= req.wdata;
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  chk_out_pair: assert property (timeout_reset == timeout_irq)
    else $error("outs differ");
  chk_one_shot: assert property (timeout_reset |=> !timeout_reset)
    else $error("long timeout");
  chk_kbc_fire: assert property ($rose(evt.kbc_reset) && mode_ff[2] |->
    ##[1:2] timeout_reset) else $error("no kbc timeout");
  chk_kb_cause: assert property ($fell(kb_n) |->
    mode_ff[1] && (timeout_reset || $past(timeout_reset))) else $error("stray pulse");
  chk_kb_quiet: assert property (timeout_reset && !mode_ff[1] |-> kb_n ##1 kb_n)
    else $error("pulse when off");
  chk_kb_long: assert property ($rose(kb_n) |-> !$past(kb_n, PULSE_CYC))
    else $error("pulse short");
  chk_kb_short: assert property ($rose(kb_n) |-> $past(kb_n, PULSE_CYC + 1))
    else $error("pulse long");
  chk_mode_rsvd: assert property ($past(req.addr) == swd_pkg::ADDR_CTRL_MODE |->
    !rdata[0] && !rdata[5]) else $error("reserved bits set");
endmodule
bind swd_watchdog swd_sva #(.PULSE_CYC(PULSE_CYC)) u_chk (.mclk(mclk), .rst(rst), .ce(ce),
  .req(req), .rdata(rdata), .evt(evt), .timeout_reset(timeout_reset),
  .timeout_irq(timeout_irq), .keyboard_reset_output_n(keyboard_reset_output_n));

//--- swd_host.sv
// Host model on the configuration data port
`timescale 1ns/1ps
module swd_host (
  input wire logic mclk,
  output swd_pkg::swd_req_t req,
  input wire logic [7:0] rdata
);
  // Port taken as unlocked, selected and active
  initial req = '0;
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge mclk);
    #1 req = {1'b1, 1'b0, a, v};
    @(posedge mclk);
    #1 req.wr = 1'b0;
    req.wdata = ~v;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge mclk);
    #1 req.addr = a;
    repeat (2) @(posedge mclk);
    #1 v = rdata;
  endtask
endmodule

//--- swd_watchdog_tb.sv
// Watchdog testbench
`timescale 1ns/1ps
module swd_watchdog_tb;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic to_rst;
  logic to_irq;
  logic kb_n;
  logic ce = 1'b1;
  logic [7:0] rdata;
  logic [7:0] d;
  swd_pkg::swd_req_t req;
  swd_pkg::swd_evt_t evt = '0;
  int err_count = 0;
  int check_count = 0;
  int n;
  int hits = 0;
  initial forever #50 mclk = ~mclk;
  always @(negedge mclk) if (to_rst === 1'b1) hits++;
  swd_host H (.mclk(mclk), .req(req), .rdata(rdata));
  swd_watchdog #(.MS_CYC(2), .PULSE_CYC(4)) DUT (.mclk(mclk), .rst(rst), .ce(ce),
    .req(req), .rdata(rdata), .evt(evt), .timeout_reset(to_rst), .timeout_irq(to_irq),
    .keyboard_reset_output_n(kb_n));
  task automatic chk(input logic ok);
    check_count++;
    if (ok !== 1'b1) begin
      err_count++;
      $display("unexpected at %0t: check %0d", $time, check_count);
    end
  endtask
  task automatic wto(input int lim);
    n = 0;
    while (to_rst !== 1'b1 && n < lim) begin
      @(posedge mclk);
      #1 n++;
    end
  endtask
  task automatic results;
    if (err_count == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic t_regs;
    H.wr(8'hf5, 8'hff);
    H.rd(8'hf5, d);
    chk(d === 8'hde);
    H.wr(8'hf7, 8'hff);
    H.rd(8'hf7, d);
    chk(d === 8'hcf);
    H.wr(8'hf8, 8'h55);
    H.rd(8'hf8, d);
    chk(d === 8'h00);
  endtask
  // Old rate may finish one last unit, so settle first
  task automatic t_exp(input logic [7:0] m, input logic [7:0] c, input int lo, input int hi);
    H.wr(8'hf5, m);
    repeat (2010) @(posedge mclk);
    H.wr(8'hf6, c);
    wto(hi + 5);
    chk(n >= lo && n <= hi);
    chk(to_irq === 1'b1 && kb_n === !m[1]);
    repeat (3) @(posedge mclk);
    #1 chk(kb_n === !m[1]);
    @(posedge mclk);
    #1 chk(kb_n === 1'b1);
  endtask
  // Clock enable low must freeze the countdown and the prescaler
  task automatic t_hold;
    H.wr(8'hf5, 8'h10);
    H.wr(8'hf6, 8'h03);
    n = hits;
    ce = 1'b0;
    repeat (100) @(posedge mclk);
    chk(hits == n);
    #1 ce = 1'b1;
    wto(20);
    chk(n >= 3 && n <= 8);
  endtask
  task automatic t_live;
    H.wr(8'hf5, 8'h10);
    H.wr(8'hf6, 8'h05);
    H.wr(8'hf6, 8'h00);
    wto(2100);
    chk(n == 2100);
    H.wr(8'hf6, 8'hff);
    H.rd(8'hf6, d);
    chk(d < 8'hff && d > 8'hf0);
    wto(600);
    chk(n > 495 && n < 515);
    H.rd(8'hf6, d);
    wto(100);
    chk(d === 8'h00 && n == 100);
  endtask
  task automatic t_reload(input int k, input logic [7:0] en);
    H.wr(8'hf7, en);
    H.wr(8'hf6, 8'h04);
    n = hits;
    repeat (10) begin
      repeat (3) @(posedge mclk);
      #1 evt[k] = 1'b1;
      @(posedge mclk);
      #1 evt[k] = 1'b0;
    end
    chk((hits == n) == (en[k+5] === 1'b1));
  endtask
  task automatic t_kbc;
    H.wr(8'hf5, 8'h04);
    H.wr(8'hf6, 8'h00);
    evt.kbc_reset = 1'b1;
    wto(4);
    chk(n < 4);
    H.wr(8'hf5, 8'h00);
    evt.kbc_reset = 1'b0;
    repeat (2) @(posedge mclk);
    #1 evt.kbc_reset = 1'b1;
    wto(20);
    chk(n == 20);
  endtask
  initial begin
    repeat (20) @(posedge mclk);
    #1 rst = 1'b0;
    t_regs;
    t_exp(8'h12, 8'h01, 0, 4);
    t_exp(8'h18, 8'h02, 115, 245);
    t_exp(8'h00, 8'h02, 1990, 4005);
    t_live;
    t_reload(2, 8'h80);
    t_reload(1, 8'h40);
    t_reload(2, 8'h40);
    t_kbc;
    t_hold;
    results;
  end
  initial begin
    #3_000_000;
    err_count++;
    results;
  end
endmodule
